/* rtl/mission_seq_defs.vh */
// Register map, field positions, reset values and fixed values
`ifndef MISSION_SEQ_DEFS_VH
`define MISSION_SEQ_DEFS_VH
`define ADDR_PG_SEL_ONE 8'h00
`define ADDR_PG_SEL_TWO 8'h01
`define ADDR_PG_SEL_THREE 8'h02
`define ADDR_PG_SEL_FOUR 8'h03
`define ADDR_CONFIG_ONE 8'h04
`define ADDR_CLK_STBY 8'h05
`define ADDR_SERIAL_CFG 8'h06
`define ADDR_ID_ONE 8'h07
`define ADDR_ID_TWO 8'h08
`define ADDR_STATUS 8'h09
`define ADDR_TRIGGER 8'h0a
`define ADDR_MEM_BASE 8'h10
`define MEM_DEPTH 21
// Power-good select four fields
`define PG_POL_BIT 6
`define PG_WIN_BIT 7
// General config one fields
`define CFG_HS_ONE_BIT 1
`define CFG_HS_TWO_BIT 2
`define CFG_ILIM_BIT 3
`define CFG_SLP1_MASK_BIT 4
`define CFG_SLP2_MASK_BIT 5
// Clock and standby control fields
`define CS_LPSTBY_BIT 1
`define CS_QUICK_BIT 2
// Trigger register fields
`define TRG_LPSTBY_BIT 0
`define TRG_SLP1_BIT 5
`define TRG_SLP2_BIT 6
`define TRG_DDR_KEEP_BIT 7
// Reset values
`define RST_PG_SEL 8'h00
`define RST_CONFIG_ONE 8'h00
`define RST_CLK_STBY 8'h3b
`define RST_SERIAL_CFG 8'h00
`define RST_ID_ONE 8'h48
`define RST_ID_TWO 8'h12
`define RST_RECOV 8'h0f
`define RST_SS_ONE 8'h02
`define RST_SS_TWO 8'hc7
`define RST_FREQ 8'h1c
`define RST_STEP 8'h0b
`define RST_RV_TIMEOUT 8'hff
`define RST_DELAY_ONE 8'h58
`define RST_DELAY_TWO 8'h9d
`define RST_GENERAL_ONE 8'h01
`define RST_WD_LONG 8'hff
`define RST_WD_THR 8'h01
// Memory indices of the plain storage registers
`define IDX_RECOV 2
`define IDX_SS_ONE 4
`define IDX_SS_TWO 5
`define IDX_FREQ 6
`define IDX_STEP 7
`define IDX_RV_ONE 8
`define IDX_RV_TWO 9
`define IDX_DELAY_ONE 13
`define IDX_DELAY_TWO 14
`define IDX_GENERAL_ONE 18
`define IDX_WD_LONG 19
`define IDX_WD_THR 20
`endif

/* rtl/setting_store.v */
// Storage for the plain read-write settings with registered read data
`timescale 1ns/1ps
`include "mission_seq_defs.vh"
module setting_store #(
   parameter DEPTH = `MEM_DEPTH,
   parameter AW = 5
) (
   input wire clock,
   input wire resetn,
   input wire wr_en,
   input wire [AW-1:0] wr_idx,
   input wire [7:0] wr_data,
   input wire [AW-1:0] rd_idx,
   output reg [7:0] rd_data
);
   reg [7:0] mem [0:DEPTH-1];
   integer i;

   function [7:0] reset_value;
      input integer idx;
      begin
         case (idx)
            `IDX_RECOV: reset_value = `RST_RECOV;
            `IDX_SS_ONE: reset_value = `RST_SS_ONE;
            `IDX_SS_TWO: reset_value = `RST_SS_TWO;
            `IDX_FREQ: reset_value = `RST_FREQ;
            `IDX_STEP: reset_value = `RST_STEP;
            `IDX_RV_ONE: reset_value = `RST_RV_TIMEOUT;
            `IDX_RV_TWO: reset_value = `RST_RV_TIMEOUT;
            `IDX_DELAY_ONE: reset_value = `RST_DELAY_ONE;
            `IDX_DELAY_TWO: reset_value = `RST_DELAY_TWO;
            `IDX_GENERAL_ONE: reset_value = `RST_GENERAL_ONE;
            `IDX_WD_LONG: reset_value = `RST_WD_LONG;
            `IDX_WD_THR: reset_value = `RST_WD_THR;
            default: reset_value = 8'h00;
         endcase
      end
   endfunction

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] <= reset_value(i);
         end
         rd_data <= 8'h00;
      end else begin
         if (wr_en) begin
            mem[wr_idx] <= wr_data;
         end
         rd_data <= mem[rd_idx];
      end
   end
endmodule

/* rtl/mission_state_sequencer.v */
// Mission state machine with power-good logic and its register port
`timescale 1ns/1ps
`include "mission_seq_defs.vh"
module mission_state_sequencer #(
   parameter NSRC = 13
) (
   input wire clock,
   input wire resetn,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   output reg reg_rvalid,
   input wire [1:0] hs_code_seen,
   input wire [1:0] bus_stop,
   output reg [1:0] port_highspeed,
   input wire mission_entry,
   input wire boot_selftest_req,
   input wire severe_err,
   input wire mcu_pwr_err,
   input wire orderly_err,
   input wire ilim_irq,
   input wire off_req,
   input wire esm_soc_err,
   input wire soc_pwr_err,
   input wire on_req,
   input wire mcu_on_req,
   input wire soc_err_return,
   input wire sleep_input_one,
   input wire sleep_input_two,
   input wire [NSRC-1:0] src_uv_ok,
   input wire [NSRC-1:0] src_ov_ok,
   output reg power_good_out,
   output reg ext_enable_drive,
   output reg ddr_supply_enable_pin,
   output reg mcu_rails_en,
   output reg soc_rails_en,
   output reg internal_ldo_en,
   output reg safe_recovery_req,
   output reg lp_standby_req,
   output reg residual_check_en,
   output reg first_startup_done,
   output reg supply_mon_ov_mask,
   output reg supply_mon_uv_mask,
   output reg selftest_logic_run,
   output reg selftest_analog_run,
   output reg [6:0] mission_state
);
   localparam [6:0] ST_HW = 7'h01;
   localparam [6:0] ST_STANDBY = 7'h02;
   localparam [6:0] ST_ACTIVE = 7'h04;
   localparam [6:0] ST_MCU = 7'h08;
   localparam [6:0] ST_SOCERR = 7'h10;
   localparam [6:0] ST_RET = 7'h20;
   localparam [6:0] ST_SAFE = 7'h40;

   reg [6:0] state_reg;
   reg [6:0] state_next;
   reg [7:0] pg_sel_one_reg, pg_sel_two_reg, pg_sel_three_reg, pg_sel_four_reg;
   reg [7:0] config_one_reg, clk_stby_reg, serial_cfg_reg, id_one_reg, id_two_reg;
   reg [7:0] trigger_reg;
   reg rd_pend_reg;
   reg mem_hit_reg;
   reg [7:0] direct_rdata_reg;
   reg lp_go;
   wire [7:0] mem_rdata;
   wire [7:0] mem_off;
   wire mem_hit;
   wire [4:0] mem_idx;
   wire [NSRC-1:0] pg_sel, src_ok;
   wire pg_valid, slp1, slp2, m1, m2, sleep_live;
   wire s1_hi, s1_lo, s2_hi, s2_lo, ilim_trig, lp_sel, ddr_keep;

   assign mem_hit = (reg_addr >= `ADDR_MEM_BASE) &&
      (reg_addr < (`ADDR_MEM_BASE + 8'd`MEM_DEPTH));
   assign mem_off = reg_addr - `ADDR_MEM_BASE;
   assign mem_idx = mem_off[4:0];

   // Plain misc and watchdog settings, freely writable
   setting_store #(
      .DEPTH(`MEM_DEPTH),
      .AW(5)
   ) u_store (
      .clock(clock),
      .resetn(resetn),
      .wr_en(reg_wr && mem_hit),
      .wr_idx(mem_idx),
      .wr_data(reg_wdata),
      .rd_idx(mem_idx),
      .rd_data(mem_rdata)
   );

   // Power-good: all selected sources valid, unselected ones ignored
   assign pg_sel = {pg_sel_four_reg[3:0], pg_sel_three_reg[3:0],
      pg_sel_two_reg[0], pg_sel_one_reg[3:0]};
   assign src_ok = pg_sel_four_reg[`PG_WIN_BIT] ? (src_uv_ok & src_ov_ok)
      : src_uv_ok;
   assign pg_valid = &(src_ok | ~pg_sel);

   // Sleep inputs and masks
   assign slp1 = sleep_input_one | trigger_reg[`TRG_SLP1_BIT];
   assign slp2 = sleep_input_two | trigger_reg[`TRG_SLP2_BIT];
   assign m1 = config_one_reg[`CFG_SLP1_MASK_BIT];
   assign m2 = config_one_reg[`CFG_SLP2_MASK_BIT];
   assign sleep_live = ~(m1 & m2);
   assign s1_hi = m1 | slp1;
   assign s1_lo = m1 | ~slp1;
   assign s2_hi = m2 | slp2;
   assign s2_lo = m2 | ~slp2;
   assign ilim_trig = ilim_irq & config_one_reg[`CFG_ILIM_BIT];
   assign lp_sel = clk_stby_reg[`CS_LPSTBY_BIT];
   assign ddr_keep = trigger_reg[`TRG_DDR_KEEP_BIT];

   // Trigger evaluation in strict priority order
   always @* begin
      state_next = state_reg;
      lp_go = 1'b0;
      case (state_reg)
         ST_HW: begin
            if (mission_entry) begin
               state_next = ST_STANDBY;
            end
         end
         ST_SAFE: begin
            state_next = ST_HW;
         end
         ST_SOCERR: begin
            if (soc_err_return) begin
               state_next = ST_MCU;
            end
         end
         default: begin
            if (severe_err || mcu_pwr_err || orderly_err || ilim_trig) begin
               state_next = ST_SAFE;
            end else if (off_req) begin
               state_next = ST_STANDBY;
               lp_go = lp_sel;
            end else if (esm_soc_err) begin
               if (state_reg == ST_ACTIVE) begin
                  state_next = ST_SOCERR;
               end
            end else if (soc_pwr_err) begin
               if (state_reg == ST_ACTIVE) begin
                  state_next = ST_MCU;
               end
            end else if (on_req) begin
               state_next = ST_ACTIVE;
            end else if (sleep_live && s1_hi && s2_hi) begin
               state_next = ST_ACTIVE;
            end else if (mcu_on_req) begin
               state_next = ST_MCU;
            end else if (sleep_live && s1_lo && s2_hi) begin
               if (state_reg != ST_STANDBY) begin
                  state_next = ST_MCU;
               end
            end else if (sleep_live && (s1_lo || s2_lo)) begin
               if (state_reg == ST_ACTIVE || state_reg == ST_MCU) begin
                  state_next = ST_RET;
               end
            end else if (!sleep_live && trigger_reg[`TRG_LPSTBY_BIT]) begin
               if (state_reg != ST_RET) begin
                  state_next = ST_STANDBY;
                  lp_go = 1'b1;
               end
            end
            if (lp_go) begin
               state_next = ST_HW;
            end
         end
      endcase
   end

   // State and rail control outputs
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_HW;
         mission_state <= ST_HW;
         ext_enable_drive <= 1'b0;
         ddr_supply_enable_pin <= 1'b0;
         mcu_rails_en <= 1'b0;
         soc_rails_en <= 1'b0;
         internal_ldo_en <= 1'b1;
         safe_recovery_req <= 1'b0;
         lp_standby_req <= 1'b0;
         power_good_out <= 1'b0;
      end else begin
         state_reg <= state_next;
         mission_state <= state_next;
         safe_recovery_req <= (state_reg == ST_SAFE);
         lp_standby_req <= lp_go;
         if (lp_go) begin
            internal_ldo_en <= 1'b0;
         end else if (mission_entry) begin
            internal_ldo_en <= 1'b1;
         end
         power_good_out <= pg_valid ^ pg_sel_four_reg[`PG_POL_BIT];
         ext_enable_drive <= (state_next == ST_ACTIVE);
         soc_rails_en <= (state_next == ST_ACTIVE);
         mcu_rails_en <= (state_next == ST_ACTIVE) || (state_next == ST_MCU) ||
            (state_next == ST_SOCERR);
         case (state_next)
            ST_ACTIVE: ddr_supply_enable_pin <= 1'b1;
            ST_RET: ddr_supply_enable_pin <= 1'b1;
            ST_MCU: begin
               if (state_reg != ST_MCU) begin
                  ddr_supply_enable_pin <= ddr_keep &
                     ddr_supply_enable_pin;
               end
            end
            default: ddr_supply_enable_pin <= 1'b0;
         endcase
      end
   end

   // Mission entry actions and boot self-test launch
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         residual_check_en <= 1'b1;
         first_startup_done <= 1'b0;
         supply_mon_ov_mask <= 1'b1;
         supply_mon_uv_mask <= 1'b1;
         selftest_logic_run <= 1'b0;
         selftest_analog_run <= 1'b0;
      end else begin
         if (mission_entry && state_reg == ST_HW) begin
            residual_check_en <= 1'b0;
            first_startup_done <= 1'b1;
            supply_mon_ov_mask <= 1'b0;
            supply_mon_uv_mask <= 1'b0;
         end
         selftest_logic_run <= boot_selftest_req;
         selftest_analog_run <= boot_selftest_req &
            ~clk_stby_reg[`CS_QUICK_BIT];
      end
   end

   // High-speed mode per port: set by the code, dropped at stop
   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1) begin : g_hs
         always @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               port_highspeed[p] <= 1'b0;
            end else if (hs_code_seen[p]) begin
               port_highspeed[p] <= 1'b1;
            end else if (bus_stop[p]) begin
               port_highspeed[p] <= 1'b0;
            end
         end
      end
   endgenerate

   // Register writes
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pg_sel_one_reg <= `RST_PG_SEL;
         pg_sel_two_reg <= `RST_PG_SEL;
         pg_sel_three_reg <= `RST_PG_SEL;
         pg_sel_four_reg <= `RST_PG_SEL;
         config_one_reg <= `RST_CONFIG_ONE;
         clk_stby_reg <= `RST_CLK_STBY;
         serial_cfg_reg <= `RST_SERIAL_CFG;
         id_one_reg <= `RST_ID_ONE;
         id_two_reg <= `RST_ID_TWO;
         trigger_reg <= 8'h00;
      end else begin
         trigger_reg[`TRG_LPSTBY_BIT] <= 1'b0;
         if (state_reg != ST_MCU && state_next == ST_MCU) begin
            trigger_reg[`TRG_DDR_KEEP_BIT] <= 1'b0;
         end
         if (reg_wr) begin
            if (reg_addr == `ADDR_PG_SEL_ONE) begin
               pg_sel_one_reg <= reg_wdata;
            end else if (reg_addr == `ADDR_PG_SEL_TWO) begin
               pg_sel_two_reg <= reg_wdata;
            end else if (reg_addr == `ADDR_PG_SEL_THREE) begin
               pg_sel_three_reg <= reg_wdata;
            end else if (reg_addr == `ADDR_PG_SEL_FOUR) begin
               pg_sel_four_reg <= reg_wdata;
            end else if (reg_addr == `ADDR_CONFIG_ONE) begin
               config_one_reg <= reg_wdata;
            end else if (reg_addr == `ADDR_CLK_STBY) begin
               clk_stby_reg <= reg_wdata;
            end else if (reg_addr == `ADDR_TRIGGER) begin
               trigger_reg <= reg_wdata;
            end else if (!first_startup_done) begin
               if (reg_addr == `ADDR_SERIAL_CFG) begin
                  serial_cfg_reg <= reg_wdata;
               end else if (reg_addr == `ADDR_ID_ONE) begin
                  id_one_reg <= reg_wdata;
               end else if (reg_addr == `ADDR_ID_TWO) begin
                  id_two_reg <= reg_wdata;
               end
            end
         end
      end
   end

   // Register reads: two cycles, unmapped reads return zero
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rd_pend_reg <= 1'b0;
         mem_hit_reg <= 1'b0;
         direct_rdata_reg <= 8'h00;
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         rd_pend_reg <= reg_rd;
         mem_hit_reg <= mem_hit;
         if (reg_addr == `ADDR_PG_SEL_ONE) begin
            direct_rdata_reg <= pg_sel_one_reg;
         end else if (reg_addr == `ADDR_PG_SEL_TWO) begin
            direct_rdata_reg <= pg_sel_two_reg;
         end else if (reg_addr == `ADDR_PG_SEL_THREE) begin
            direct_rdata_reg <= pg_sel_three_reg;
         end else if (reg_addr == `ADDR_PG_SEL_FOUR) begin
            direct_rdata_reg <= pg_sel_four_reg;
         end else if (reg_addr == `ADDR_CONFIG_ONE) begin
            direct_rdata_reg <= {config_one_reg[7:3], port_highspeed,
               config_one_reg[0]};
         end else if (reg_addr == `ADDR_CLK_STBY) begin
            direct_rdata_reg <= clk_stby_reg;
         end else if (reg_addr == `ADDR_SERIAL_CFG) begin
            direct_rdata_reg <= serial_cfg_reg;
         end else if (reg_addr == `ADDR_ID_ONE) begin
            direct_rdata_reg <= id_one_reg;
         end else if (reg_addr == `ADDR_ID_TWO) begin
            direct_rdata_reg <= id_two_reg;
         end else if (reg_addr == `ADDR_STATUS) begin
            direct_rdata_reg <= {first_startup_done, state_reg};
         end else if (reg_addr == `ADDR_TRIGGER) begin
            direct_rdata_reg <= trigger_reg;
         end else begin
            direct_rdata_reg <= 8'h00;
         end
         reg_rvalid <= rd_pend_reg;
         if (rd_pend_reg) begin
            reg_rdata <= mem_hit_reg ? mem_rdata : direct_rdata_reg;
         end
      end
   end
endmodule

/* dv/seq_state_monitor.sv */
// Port-level assertions for the mission state sequencer
`timescale 1ns/1ps
module seq_state_monitor (
   input wire clock,
   input wire resetn,
   input wire mission_entry,
   input wire boot_selftest_req,
   input wire severe_err,
   input wire mcu_pwr_err,
   input wire orderly_err,
   input wire ilim_irq,
   input wire off_req,
   input wire esm_soc_err,
   input wire soc_pwr_err,
   input wire on_req,
   input wire soc_err_return,
   input wire [1:0] hs_code_seen,
   input wire [1:0] port_highspeed,
   input wire ext_enable_drive,
   input wire ddr_supply_enable_pin,
   input wire mcu_rails_en,
   input wire soc_rails_en,
   input wire safe_recovery_req,
   input wire residual_check_en,
   input wire first_startup_done,
   input wire supply_mon_ov_mask,
   input wire supply_mon_uv_mask,
   input wire selftest_logic_run,
   input wire [6:0] mission_state
);
   default clocking mon_cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   wire in_hw = mission_state == 7'h01;
   wire in_stby = mission_state == 7'h02;
   wire in_act = mission_state == 7'h04;
   wire in_mcu = mission_state == 7'h08;
   wire in_soc = mission_state == 7'h10;
   wire in_ret = mission_state == 7'h20;
   wire in_safe = mission_state == 7'h40;
   wire [3:0] drv = {ext_enable_drive, ddr_supply_enable_pin, mcu_rails_en, soc_rails_en};
   wire quiet = !(severe_err || mcu_pwr_err || orderly_err || ilim_irq || off_req
      || esm_soc_err || soc_pwr_err);
   chk_standby_all_off: assert property (in_stby |-> drv == 4'h0)
      else $error("Standby with a drive on");
   chk_active_all_on: assert property (in_act |-> drv == 4'hf)
      else $error("Active with a drive off");
   chk_retention_ddr_only: assert property (in_ret |-> drv == 4'h4)
      else $error("Retention drives wrong");
   chk_mcu_only_rails: assert property (in_mcu |-> {drv[3], drv[1:0]} == 3'b010)
      else $error("MCU-only rails wrong");
   chk_socerr_one_trigger: assert property (in_soc && !soc_err_return |=> in_soc
      && drv[1:0] == 2'b10)
      else $error("SoC-error state left or rails wrong");
   chk_socerr_return: assert property (in_soc && soc_err_return |=> in_mcu)
      else $error("SoC-error return not taken");
   chk_entry_actions: assert property (in_hw && mission_entry |=> in_stby
      && first_startup_done && !residual_check_en && !supply_mon_ov_mask && !supply_mon_uv_mask)
      else $error("Entry actions missing");
   chk_safe_then_recovery: assert property (in_safe |=> in_hw && safe_recovery_req
      ##1 !safe_recovery_req)
      else $error("Safe exit wrong");
   chk_error_to_safe: assert property (in_act && severe_err |=> in_safe)
      else $error("Error did not reach safe");
   chk_on_request: assert property (in_stby && on_req && quiet |=> in_act)
      else $error("On request not honoured");
   chk_highspeed_cause: assert property ($rose(port_highspeed[1])
      |-> $past(hs_code_seen[1]))
      else $error("High speed without code");
   chk_selftest_launch: assert property (boot_selftest_req |=> selftest_logic_run)
      else $error("Self-test not launched");
   cover property (in_act ##1 in_mcu);
   cover property (in_soc);
   cover property (in_ret);
endmodule
bind mission_state_sequencer seq_state_monitor seq_state_monitor_inst (.clock, .resetn,
   .mission_entry, .boot_selftest_req, .severe_err, .mcu_pwr_err, .orderly_err, .ilim_irq,
   .off_req, .esm_soc_err, .soc_pwr_err, .on_req, .soc_err_return, .hs_code_seen,
   .port_highspeed, .ext_enable_drive, .ddr_supply_enable_pin, .mcu_rails_en, .soc_rails_en,
   .safe_recovery_req, .residual_check_en, .first_startup_done, .supply_mon_ov_mask,
   .supply_mon_uv_mask, .selftest_logic_run, .mission_state);

/* dv/host_port_model.sv */
// Host model driving the register port and the error return request
`timescale 1ns/1ps
module host_port_model (
   input wire clock,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic soc_err_return,
   input wire [7:0] reg_rdata,
   input wire reg_rvalid
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      soc_err_return = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clock);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      d = 8'hxx;
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clock);
      #1;
      reg_rd = 1'b0;
      repeat (3) begin
         @(posedge clock);
         #1;
         if (reg_rvalid === 1'b1) d = reg_rdata;
      end
   endtask
   // Return is only requested once the causing errors are cleared
   task automatic socerr_return(input logic errors_cleared);
      if (errors_cleared) begin
         @(posedge clock);
         #1;
         soc_err_return = 1'b1;
         @(posedge clock);
         #1;
         soc_err_return = 1'b0;
      end
   endtask
endmodule

/* dv/pmic_mission_state_sequencer_tb.sv */
// Directed bench for the mission state sequencer
`timescale 1ns/1ps
module pmic_mission_state_sequencer_tb;
   logic clock, resetn, mission_entry, boot_selftest_req, severe_err, ilim_irq, off_req;
   logic esm_soc_err, on_req, sleep_input_one, sleep_input_two;
   logic [1:0] hs_code_seen, bus_stop;
   logic [12:0] src_uv_ok, src_ov_ok;
   wire [7:0] reg_addr, reg_wdata, reg_rdata;
   wire [6:0] mission_state;
   wire [1:0] port_highspeed;
   wire reg_wr, reg_rd, reg_rvalid, soc_err_return, power_good_out, ext_enable_drive;
   wire ddr_supply_enable_pin, mcu_rails_en, soc_rails_en, internal_ldo_en, safe_recovery_req;
   wire lp_standby_req, residual_check_en, first_startup_done, supply_mon_ov_mask;
   wire supply_mon_uv_mask, selftest_logic_run, selftest_analog_run;
   wire [7:0] st = {1'b0, mission_state};
   wire [7:0] drv = {4'h0, ext_enable_drive, ddr_supply_enable_pin, mcu_rails_en, soc_rails_en};
   wire [7:0] pg = {7'h0, power_good_out};
   integer errors = 0;
   integer compares = 0;
   integer cycles = 0;
   mission_state_sequencer mission_state_sequencer_inst (
      .clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
      .hs_code_seen, .bus_stop, .port_highspeed, .mission_entry, .boot_selftest_req,
      .severe_err, .mcu_pwr_err(1'b0), .orderly_err(1'b0), .ilim_irq, .off_req, .esm_soc_err,
      .soc_pwr_err(1'b0), .on_req, .mcu_on_req(1'b0), .soc_err_return, .sleep_input_one,
      .sleep_input_two, .src_uv_ok, .src_ov_ok, .power_good_out, .ext_enable_drive,
      .ddr_supply_enable_pin, .mcu_rails_en, .soc_rails_en, .internal_ldo_en,
      .safe_recovery_req, .lp_standby_req, .residual_check_en, .first_startup_done,
      .supply_mon_ov_mask, .supply_mon_uv_mask, .selftest_logic_run, .selftest_analog_run,
      .mission_state);
   host_port_model host_port_model_inst (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .soc_err_return, .reg_rdata, .reg_rvalid);
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task wrap_up;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errors = errors + 1;
         wrap_up;
      end
   end
   task step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         errors = errors + 1;
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      host_port_model_inst.wr(a, d);
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host_port_model_inst.rd(a, d);
      chk(d, exp);
   endtask
   task t_defaults;
      chk(st, 8'h01);
      for (int i = 0; i < 4; i++) rd_chk(8'(i), 8'h00);
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h05, 8'h3b);
      rd_chk(8'h07, 8'h48);
      rd_chk(8'h08, 8'h12);
      rd_chk(8'h24, 8'h01);
   endtask
   task t_power_good;
      wr(8'h00, 8'h01);
      src_uv_ok[1] = 1'b0;
      step(3);
      chk(pg, 8'h01);
      src_uv_ok[0] = 1'b0;
      step(3);
      chk(pg, 8'h00);
      src_uv_ok = {13{1'b1}};
      src_ov_ok[0] = 1'b0;
      step(3);
      chk(pg, 8'h01);
      wr(8'h03, 8'h80);
      step(3);
      chk(pg, 8'h00);
      src_ov_ok = {13{1'b1}};
      wr(8'h03, 8'h00);
      wr(8'h00, 8'h00);
   endtask
   task t_entry;
      mission_entry = 1'b1;
      step(1);
      mission_entry = 1'b0;
      chk({first_startup_done, residual_check_en, supply_mon_ov_mask,
         supply_mon_uv_mask, st[3:0]}, 8'h82);
      rd_chk(8'h09, 8'h82);
      wr(8'h07, 8'h55);
      wr(8'h06, 8'h07);
      wr(8'h10, 8'h5a);
      wr(8'h09, 8'hff);
      rd_chk(8'h07, 8'h48);
      rd_chk(8'h06, 8'h00);
      rd_chk(8'h10, 8'h5a);
      rd_chk(8'h09, 8'h82);
      rd_chk(8'h30, 8'h00);
   endtask
   task t_hs_selftest;
      hs_code_seen = 2'b10;
      step(1);
      hs_code_seen = 2'b00;
      chk({6'h0, port_highspeed}, 8'h02);
      rd_chk(8'h04, 8'h04);
      bus_stop = 2'b10;
      step(1);
      bus_stop = 2'b00;
      chk({6'h0, port_highspeed}, 8'h00);
      boot_selftest_req = 1'b1;
      step(1);
      boot_selftest_req = 1'b0;
      chk({6'h0, selftest_logic_run, selftest_analog_run}, 8'h03);
   endtask
   task t_wake;
      step(5);
      chk(st, 8'h02);
      chk(drv, 8'h00);
      on_req = 1'b1;
      step(1);
      chk(drv, 8'h0f);
      {sleep_input_one, sleep_input_two} = 2'b11;
      on_req = 1'b0;
      wr(8'h0a, 8'ha0);
      sleep_input_one = 1'b0;
      step(2);
      chk(st, 8'h04);
      wr(8'h0a, 8'h80);
      step(2);
      chk({st[3:0], drv[3:0]}, 8'h86);
      sleep_input_two = 1'b0;
      step(2);
      chk({st[7:4], drv[3:0]}, 8'h24);
      {sleep_input_one, sleep_input_two} = 2'b11;
      step(2);
      sleep_input_one = 1'b0;
      step(2);
      chk({st[3:0], drv[3:0]}, 8'h82);
      sleep_input_one = 1'b1;
      wr(8'h04, 8'h10);
      sleep_input_one = 1'b0;
      step(2);
      chk(st, 8'h04);
      wr(8'h04, 8'h00);
      step(2);
      chk(st, 8'h08);
      sleep_input_one = 1'b1;
      step(2);
   endtask
   task t_socerr;
      esm_soc_err = 1'b1;
      step(2);
      chk({st[7:4], drv[3:0]}, 8'h12);
      {on_req, off_req} = 2'b11;
      step(2);
      chk(st, 8'h10);
      {on_req, off_req, esm_soc_err} = 3'b000;
      host_port_model_inst.socerr_return(1'b1);
      chk(st, 8'h08);
      step(2);
   endtask
   task t_faults;
      ilim_irq = 1'b1;
      step(2);
      chk(st, 8'h04);
      ilim_irq = 1'b0;
      wr(8'h04, 8'h08);
      ilim_irq = 1'b1;
      step(1);
      ilim_irq = 1'b0;
      chk(st, 8'h40);
      step(1);
      chk({st[3:0], drv[3:0]}, 8'h10);
      chk({7'h0, safe_recovery_req}, 8'h01);
      wr(8'h04, 8'h00);
      {sleep_input_one, sleep_input_two} = 2'b00;
      mission_entry = 1'b1;
      step(1);
      mission_entry = 1'b0;
      chk({st[3:0], drv[3:0]}, 8'h20);
   endtask
   task t_lp_standby;
      on_req = 1'b1;
      step(2);
      off_req = 1'b1;
      step(1);
      off_req = 1'b0;
      chk({st[3:0], lp_standby_req, internal_ldo_en, 2'b00}, 8'h18);
      on_req = 1'b0;
      mission_entry = 1'b1;
      step(1);
      mission_entry = 1'b0;
      wr(8'h05, 8'h39);
      on_req = 1'b1;
      step(2);
      off_req = 1'b1;
      step(2);
      chk(st, 8'h02);
      off_req = 1'b0;
      step(2);
      severe_err = 1'b1;
      step(1);
      chk(st, 8'h40);
      {on_req, severe_err} = 2'b00;
   endtask
   initial begin
      resetn = 1'b0;
      {mission_entry, boot_selftest_req, severe_err, ilim_irq, off_req} = 5'h00;
      {esm_soc_err, on_req, sleep_input_one, sleep_input_two} = 4'h0;
      {hs_code_seen, bus_stop} = 4'h0;
      src_uv_ok = {13{1'b1}};
      src_ov_ok = {13{1'b1}};
      step(4);
      resetn = 1'b1;
      t_defaults;
      t_power_good;
      t_entry;
      t_hs_selftest;
      t_wake;
      t_socerr;
      t_faults;
      t_lp_standby;
      wrap_up;
   end
endmodule
